// ==== design/usb_cpu_port.sv ====
`timescale 1ns/1ns
// Function
// RULE_01: width strap sampled when reset releases; low narrow, high wide.
// RULE_02: host holds strap pin low throughout when narrow bus chosen.
// RULE_03: narrow bus keeps fifo byte-wide; lower strobe writes fifo.
// RULE_04: wide bus: lane mode zero gives word fifo, one byte fifo.
// RULE_05: word fifo: both strobes write word; lower alone writes low byte.
// RULE_06: byte fifo on wide bus: lower lanes write, read mirrors byte both lanes.
// RULE_07: narrow register access decodes address six to zero; lower lanes float idle.
// RULE_08: wide register write decodes six to one; each strobe writes its byte.
// RULE_09: wide read drives both bytes; deselected all sixteen lanes float.
// RULE_10: narrow bus uses shared data15 pin as address zero.
// RULE_11: internal clock 48 MHz; pll ratio set by input-frequency select.
// RULE_12: host disables pll when 48 MHz input supplied.
// RULE_13: oscillator, pll and usb clock each stop by their enable bit.
// RULE_14: host wakes oscillator, pll, then usb clock in order.
// RULE_15: out bulk continuous mode stops after programmed transaction count.
// RULE_16: forced toggle gives cpu the serial-engine buffer half and its count.
// RULE_17: usb clock gate glitch-free; usb block idle until enabled after lock.
module usb_cpu_port #(
  parameter int OSC_CYC = cpu_port_pkg::OSC_SETTLE_CYC,
  parameter int PLL_CYC = cpu_port_pkg::PLL_LOCK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic lower_write_strobe_n,
  input wire logic upper_wstrobe_width_sel,
  input wire logic [cpu_port_pkg::ADDR_W-1:1] addr,
  input wire logic [cpu_port_pkg::DATA_W-1:0] data_in,
  output logic [cpu_port_pkg::DATA_W-1:0] data_out,
  output logic [1:0] data_oe_n,
  input wire logic fifo_is_target,
  input wire logic byte_lane_mode,
  output logic reg_wr,
  output logic [1:0] reg_wr_be,
  output logic reg_rd,
  output logic [cpu_port_pkg::ADDR_W-1:0] reg_addr,
  output logic [cpu_port_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [cpu_port_pkg::DATA_W-1:0] reg_rdata,
  output logic fifo_wr,
  output logic fifo_wr_word,
  output logic fifo_rd,
  output logic [cpu_port_pkg::DATA_W-1:0] fifo_wdata,
  input wire logic [cpu_port_pkg::DATA_W-1:0] fifo_rdata,
  output logic wide_bus,
  output logic fifo_byte_access,
  input wire logic continuous_mode,
  input wire logic [cpu_port_pkg::CNT_W-1:0] transaction_count,
  input wire logic count_load,
  input wire logic max_packet_rx,
  output logic out_transfer_stop,
  input wire logic force_toggle,
  input wire logic [cpu_port_pkg::FIFO_BYTE_CNT_W-1:0] sie_rx_count,
  output logic sie_toggle,
  output logic [cpu_port_pkg::FIFO_BYTE_CNT_W-1:0] sie_count_out,
  input wire logic osc_enable_bit,
  input wire logic pll_run_bit,
  input wire logic usb_clock_enable_bit,
  input wire logic [1:0] input_freq_select,
  output logic osc_run,
  output logic pll_on,
  output logic pll_locked,
  output logic [5:0] pll_ratio,
  output logic usb_clk_en
);
  import cpu_port_pkg::*;

  logic strap_pending_reg;
  logic wide_reg;
  logic access_reg;
  logic [CNT_W-1:0] tx_left_reg;
  logic fifo_byte;
  logic upper_n;
  logic wr_lo;
  logic wr_hi;
  logic rd_now;
  logic [ADDR_W-1:0] dec_addr;

  function automatic logic [DATA_W-1:0] mirror_low(input logic [DATA_W-1:0] d);
    mirror_low = {d[BYTE_W-1:0], d[BYTE_W-1:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // strap capture: first clocked edge after release, never under async reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strap_pending_reg <= 1'b1;
      wide_reg <= WIDTH_NARROW;
    end else if (strap_pending_reg) begin
      strap_pending_reg <= 1'b0;
      wide_reg <= upper_wstrobe_width_sel; // RULE_01
    end
  end

  // on a narrow bus the strap pin stays low, but upper_n is forced high, so it never acts as a strobe
  assign upper_n = wide_reg ? upper_wstrobe_width_sel : 1'b1; // RULE_02
  assign fifo_byte = !wide_reg || (byte_lane_mode == LANE_BYTE); // RULE_03 RULE_04
  // narrow bus: a write is cs, lower strobe low, read high
  assign wr_lo = !cs_n && rd_n && !lower_write_strobe_n; // RULE_07
  assign wr_hi = !cs_n && rd_n && !upper_n && !(fifo_is_target && fifo_byte);
  assign rd_now = !cs_n && !rd_n && lower_write_strobe_n && upper_n;
  // narrow bus: data15 pin carries address bit zero
  assign dec_addr = wide_reg ? {addr, 1'b0} : {addr, data_in[DATA_W-1]}; // RULE_07 RULE_08 RULE_10

  ////////////////////////////////////////////////////////////////////////
  // one request per strobe assertion; strobes are held for many clocks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      access_reg <= 1'b0;
      reg_wr <= 1'b0;
      reg_wr_be <= '0;
      reg_rd <= 1'b0;
      reg_addr <= '0;
      reg_wdata <= '0;
      fifo_wr <= 1'b0;
      fifo_wr_word <= 1'b0;
      fifo_rd <= 1'b0;
      fifo_wdata <= '0;
    end else begin
      access_reg <= wr_lo || wr_hi || rd_now;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      fifo_wr <= 1'b0;
      fifo_rd <= 1'b0;
      if (!access_reg && (wr_lo || wr_hi || rd_now)) begin
        if (fifo_is_target) begin
          fifo_wr <= wr_lo; // RULE_03 RULE_05 RULE_06
          fifo_wr_word <= wr_lo && wr_hi && !fifo_byte; // RULE_05
          fifo_rd <= rd_now;
          // a byte write only carries the lower lanes, even in word mode
          fifo_wdata <= (wr_hi && !fifo_byte) ? data_in : {{BYTE_W{1'b0}}, data_in[BYTE_W-1:0]}; // RULE_05
        end else begin
          reg_wr <= wr_lo || wr_hi;
          reg_wr_be <= {wr_hi, wr_lo}; // RULE_08
          reg_rd <= rd_now;
          reg_addr <= dec_addr;
          reg_wdata <= data_in;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read lanes; upper lane stays off on a narrow bus
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_out <= '0;
      data_oe_n <= 2'h3;
    end else if (rd_now) begin
      data_oe_n <= wide_reg ? 2'h0 : 2'h2; // RULE_09
      if (fifo_is_target) begin
        data_out <= fifo_byte ? mirror_low(fifo_rdata) : fifo_rdata; // RULE_06
      end else begin
        data_out <= reg_rdata;
      end
    end else begin
      data_oe_n <= 2'h3; // RULE_07 RULE_09
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wide_bus <= 1'b0;
      fifo_byte_access <= 1'b1;
    end else begin
      wide_bus <= wide_reg;
      fifo_byte_access <= fifo_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transaction counter; a zero count in continuous mode blocks at once
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_left_reg <= '0;
      out_transfer_stop <= 1'b0;
    end else begin
      if (count_load) begin
        tx_left_reg <= transaction_count;
      end else if (max_packet_rx && continuous_mode && tx_left_reg != '0) begin
        tx_left_reg <= tx_left_reg - 1'b1; // RULE_15
      end
      out_transfer_stop <= continuous_mode && (count_load ? (transaction_count == '0) :
        (tx_left_reg == '0 || (tx_left_reg == CNT_W'(1) && max_packet_rx))); // RULE_15
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sie_toggle <= 1'b0;
      sie_count_out <= '0;
    end else begin
      sie_toggle <= force_toggle; // RULE_16
      if (force_toggle) begin
        sie_count_out <= sie_rx_count; // RULE_16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  usb_clock_seq #(
    .OSC_CYC(OSC_CYC),
    .PLL_CYC(PLL_CYC)
  ) u_clock_seq (
    .ref_clk(ref_clk),
    .rst(rst),
    .osc_enable_bit(osc_enable_bit),
    .pll_run_bit(pll_run_bit),
    .usb_clock_enable_bit(usb_clock_enable_bit),
    .input_freq_select(input_freq_select),
    .osc_run(osc_run),
    .pll_on(pll_on),
    .pll_locked(pll_locked),
    .pll_ratio(pll_ratio),
    .usb_clk_en(usb_clk_en)
  );
endmodule // usb_cpu_port

// ==== design/cpu_port_pkg.sv ====
package cpu_port_pkg;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam int CNT_W = 8;
  localparam int FIFO_BYTE_CNT_W = 10;
  // bus width strap encoding
  localparam logic WIDTH_NARROW = 1'b0;
  localparam logic WIDTH_WIDE = 1'b1;
  // byte-lane mode bit encoding
  localparam logic LANE_WORD = 1'b0;
  localparam logic LANE_BYTE = 1'b1;
  // input-frequency select encoding (pll ratio = 48 / input)
  localparam logic [1:0] FREQ_6MHZ = 2'h0;
  localparam logic [1:0] FREQ_12MHZ = 2'h1;
  localparam logic [1:0] FREQ_24MHZ = 2'h2;
  localparam logic [1:0] FREQ_48MHZ = 2'h3;
  localparam logic [5:0] PLL_RATIO_6 = 6'h08;
  localparam logic [5:0] PLL_RATIO_12 = 6'h04;
  localparam logic [5:0] PLL_RATIO_24 = 6'h02;
  localparam logic [5:0] PLL_RATIO_1 = 6'h01;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int OSC_SETTLE_NS = 1000;
  localparam int PLL_LOCK_US = 1000;
  localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 17;
  typedef enum logic [1:0] {
    CLK_OFF = 2'b00,
    CLK_OSC_WAIT = 2'b01,
    CLK_PLL_WAIT = 2'b11,
    CLK_LOCKED = 2'b10
  } clk_state_t;
endpackage

// ==== design/usb_clock_seq.sv ====
`timescale 1ns/1ns
module usb_clock_seq #(
  parameter int OSC_CYC = cpu_port_pkg::OSC_SETTLE_CYC,
  parameter int PLL_CYC = cpu_port_pkg::PLL_LOCK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic osc_enable_bit,
  input wire logic pll_run_bit,
  input wire logic usb_clock_enable_bit,
  input wire logic [1:0] input_freq_select,
  output logic osc_run,
  output logic pll_on,
  output logic pll_locked,
  output logic [5:0] pll_ratio,
  output logic usb_clk_en
);
  import cpu_port_pkg::*;
  clk_state_t state_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic pll_bypass;

  ////////////////////////////////////////////////////////////////////////
  // ratio choice; at 48 MHz input the pll is bypassed
  assign pll_bypass = (input_freq_select == FREQ_48MHZ);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pll_ratio <= PLL_RATIO_1;
    end else begin
      case (input_freq_select) // RULE_11
        FREQ_6MHZ: pll_ratio <= PLL_RATIO_6;
        FREQ_12MHZ: pll_ratio <= PLL_RATIO_12;
        FREQ_24MHZ: pll_ratio <= PLL_RATIO_24;
        default: pll_ratio <= PLL_RATIO_1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= CLK_OFF;
      timer_reg <= '0;
    end else if (!osc_enable_bit) begin
      state_reg <= CLK_OFF; // RULE_13
      timer_reg <= '0;
    end else begin
      case (state_reg)
        CLK_OFF: begin
          state_reg <= CLK_OSC_WAIT;
          timer_reg <= TIMER_W'(OSC_CYC);
        end
        CLK_OSC_WAIT: begin
          if (timer_reg != '0) begin
            timer_reg <= timer_reg - 1'b1;
          end else if (pll_run_bit || pll_bypass) begin
            state_reg <= CLK_PLL_WAIT;
            timer_reg <= pll_bypass ? '0 : TIMER_W'(PLL_CYC);
          end
        end
        CLK_PLL_WAIT: begin
          if (!pll_run_bit && !pll_bypass) begin
            state_reg <= CLK_OSC_WAIT; // RULE_13
          end else if (timer_reg != '0) begin
            timer_reg <= timer_reg - 1'b1;
          end else begin
            state_reg <= CLK_LOCKED;
          end
        end
        default: begin
          if (!pll_run_bit && !pll_bypass) begin
            state_reg <= CLK_OSC_WAIT;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gate changes only on a clock edge from a flop, so the enable never glitches
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      osc_run <= 1'b0;
      pll_on <= 1'b0;
      pll_locked <= 1'b0;
      usb_clk_en <= 1'b0;
    end else begin
      osc_run <= osc_enable_bit; // RULE_13
      pll_on <= osc_enable_bit && pll_run_bit && !pll_bypass;
      pll_locked <= (state_reg == CLK_LOCKED);
      usb_clk_en <= (state_reg == CLK_LOCKED) && usb_clock_enable_bit; // RULE_17
    end
  end
endmodule // usb_clock_seq

// ==== tb/usb_cpu_port_assertions.sv ====
`timescale 1ns/1ns
module usb_cpu_port_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic [1:0] data_oe_n,
  input wire logic byte_lane_mode,
  input wire logic reg_wr,
  input wire logic wide_bus,
  input wire logic fifo_byte_access,
  input wire logic continuous_mode,
  input wire logic [7:0] transaction_count,
  input wire logic count_load,
  input wire logic out_transfer_stop,
  input wire logic force_toggle,
  input wire logic [9:0] sie_rx_count,
  input wire logic sie_toggle,
  input wire logic [9:0] sie_count_out,
  input wire logic usb_clock_enable_bit,
  input wire logic [1:0] input_freq_select,
  input wire logic pll_locked,
  input wire logic [5:0] pll_ratio,
  input wire logic usb_clk_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  wr_once_a: assert property (reg_wr |=> !reg_wr)
    else $error("write pulse held");
  upper_off_a: assert property (!wide_bus |-> data_oe_n[1])
    else $error("upper lane driven on narrow bus");
  desel_a: assert property (cs_n && $past(cs_n) |-> data_oe_n == 2'h3)
    else $error("lanes driven while deselected");
  narrow_byte_a: assert property (!wide_bus |-> fifo_byte_access)
    else $error("word fifo on narrow bus");
  // two cycles of history so the strap edge itself is never judged
  lane_mode_a: assert property (wide_bus && $past(wide_bus, 2) && $stable(byte_lane_mode)
    |-> fifo_byte_access == byte_lane_mode) else $error("fifo width mismatch");
  stop_load_a: assert property (count_load && continuous_mode
    |=> out_transfer_stop == ($past(transaction_count) == 8'h00)) else $error("stop after load");
  toggle_a: assert property (force_toggle
    |=> sie_toggle && sie_count_out == $past(sie_rx_count)) else $error("toggle capture");
  ratio_a: assert property ($stable(input_freq_select)
    |=> pll_ratio == (6'h08 >> $past(input_freq_select))) else $error("pll ratio");
  usb_gate_a: assert property (usb_clk_en
    |-> $past(pll_locked) && $past(usb_clock_enable_bit)) else $error("usb clock early");
  cover property (count_load ##1 out_transfer_stop);
  cover property ($rose(usb_clk_en));
  cover property (wide_bus && fifo_byte_access && !data_oe_n[0]);
endmodule // usb_cpu_port_assertions
bind usb_cpu_port usb_cpu_port_assertions u_usb_cpu_port_assertions (.*);

// ==== tb/host_cpu_model.sv ====
`timescale 1ns/1ns
module host_cpu_model (
  input wire logic ref_clk,
  output logic cs_n,
  output logic rd_n,
  output logic lower_write_strobe_n,
  output logic upper_wstrobe_width_sel,
  output logic [5:0] addr,
  output logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic [1:0] data_oe_n
);
  logic wide = 1'b0;
  task automatic idle();
    cs_n = 1'b1;
    rd_n = 1'b1;
    lower_write_strobe_n = 1'b1;
    upper_wstrobe_width_sel = wide;
  endtask
  initial begin
    idle();
    addr = 6'h00;
    data_in = 16'h0000;
  end
  // no ready on this bus: hold two edges, then a full idle cycle
  task automatic acc(input logic rd, input logic [1:0] we, input logic [6:0] a,
                     input logic [15:0] d, output logic [17:0] q);
    @(negedge ref_clk);
    cs_n = 1'b0;
    rd_n = !rd;
    lower_write_strobe_n = !we[0];
    upper_wstrobe_width_sel = wide & !we[1];
    addr = a[6:1];
    data_in = wide ? d : {a[0], 7'h00, d[7:0]};
    repeat (2) @(negedge ref_clk);
    q = {data_oe_n, data_out};
    idle();
    // released lanes flip so a stale value never looks valid
    data_in = ~data_in;
    @(negedge ref_clk);
  endtask
endmodule // host_cpu_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b0;
  logic cs_n, rd_n, lower_write_strobe_n, upper_wstrobe_width_sel;
  logic [5:0] addr, pll_ratio;
  logic [15:0] data_in, data_out, reg_wdata, fifo_wdata;
  logic [1:0] data_oe_n, reg_wr_be;
  logic [6:0] reg_addr;
  logic [9:0] sie_count_out;
  logic reg_wr, reg_rd, fifo_wr, fifo_wr_word, fifo_rd, wide_bus, fifo_byte_access;
  logic out_transfer_stop, sie_toggle, osc_run, pll_on, pll_locked, usb_clk_en;
  logic fifo_is_target = 1'b0, byte_lane_mode = 1'b0, continuous_mode = 1'b1;
  logic count_load = 1'b0, max_packet_rx = 1'b0, force_toggle = 1'b0;
  logic osc_enable_bit = 1'b0, pll_run_bit = 1'b0, usb_clock_enable_bit = 1'b0;
  logic [15:0] reg_rdata = 16'h5AC3, fifo_rdata = 16'h7E81;
  logic [7:0] transaction_count = 8'h02;
  logic [9:0] sie_rx_count = 10'h2A5;
  logic [1:0] input_freq_select = 2'h0;
  logic [24:0] rcap;
  logic [16:0] fcap;
  logic [17:0] q;
  int err_total = 0, cmp_count = 0, cyc = 0, nw = 0;
  usb_cpu_port #(.OSC_CYC(4), .PLL_CYC(10)) u_usb_cpu_port (.*);
  host_cpu_model u_host_cpu_model (.*);
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (reg_wr || reg_rd) rcap <= {reg_wr_be, reg_addr, reg_wdata};
    if (fifo_wr) fcap <= {fifo_wr_word, fifo_wdata};
    nw <= nw + int'(reg_wr) + int'(fifo_wr) + int'(reg_rd) + int'(fifo_rd);
    if (cyc == 3000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [24:0] e, input logic [24:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  // strap level is parked on the pin before reset is raised
  task automatic reset_to(input logic w);
    u_host_cpu_model.wide = w;
    u_host_cpu_model.idle();
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic wr(input logic f, input logic [1:0] we, input logic [6:0] a, input logic [15:0] d);
    int n;
    n = nw;
    fifo_is_target = f;
    u_host_cpu_model.acc(1'b0, we, a, d, q);
    chk("pulses", 25'(n + 1), 25'(nw));
  endtask
  task automatic rd(input logic f, input logic [6:0] a);
    int n;
    n = nw;
    fifo_is_target = f;
    u_host_cpu_model.acc(1'b1, 2'b00, a, 16'h0000, q);
    chk("read pulses", 25'(n + 1), 25'(nw));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_narrow();
    reset_to(1'b0);
    chk("wide_bus", 25'h0, 25'(wide_bus));
    chk("byte access", 25'h1, 25'(fifo_byte_access));
    wr(1'b0, 2'b11, 7'h35, 16'h00A5);
    chk("narrow write", 25'({2'b01, 7'h35, 8'hA5}), 25'({rcap[24:16], rcap[7:0]}));
    rd(1'b0, 7'h21);
    chk("narrow read", 25'({2'b10, 8'hC3}), 25'({q[17:16], q[7:0]}));
    chk("read addr", 25'h21, 25'(rcap[22:16]));
    wr(1'b1, 2'b01, 7'h00, 16'h1234);
    chk("narrow fifo", 25'h00034, 25'(fcap));
  endtask
  task automatic t_wide();
    reset_to(1'b1);
    chk("wide_bus", 25'h1, 25'(wide_bus));
    for (int i = 1; i < 4; i++) begin
      wr(1'b0, 2'(i), 7'h2A, 16'hC35A);
      chk("wide write", {2'(i), 7'h2A, 16'hC35A}, rcap);
    end
    rd(1'b0, 7'h2A);
    chk("wide read", 25'h05AC3, 25'(q));
    chk("wide read addr", 25'h2A, 25'(rcap[22:16]));
    @(negedge ref_clk);
    chk("lanes off", 25'h3, 25'(data_oe_n));
    wr(1'b1, 2'b11, 7'h00, 16'hBEEF);
    chk("word fifo", 25'h1BEEF, 25'(fcap));
    wr(1'b1, 2'b01, 7'h00, 16'hBEEF);
    chk("byte of word", 25'h000EF, 25'(fcap));
    byte_lane_mode = 1'b1;
    wr(1'b1, 2'b01, 7'h00, 16'h1234);
    chk("byte fifo", 25'h00034, 25'(fcap));
    rd(1'b1, 7'h00);
    chk("mirror read", 25'h08181, 25'(q));
  endtask
  task automatic t_count();
    for (int i = 0; i < 4; i++) begin
      if (i == 3) transaction_count = 8'h00;
      count_load = (i == 0 || i == 3);
      max_packet_rx = (i == 1 || i == 2);
      @(negedge ref_clk);
      count_load = 1'b0;
      max_packet_rx = 1'b0;
      @(negedge ref_clk);
      chk("stop", 25'(i >= 2), 25'(out_transfer_stop));
    end
  endtask
  task automatic t_toggle();
    force_toggle = 1'b1;
    @(negedge ref_clk);
    chk("toggle pulse", 25'h1, 25'(sie_toggle));
    force_toggle = 1'b0;
    sie_rx_count = 10'h15A;
    repeat (2) @(negedge ref_clk);
    chk("rx count", 25'h2A5, 25'(sie_count_out));
    chk("toggle end", 25'h0, 25'(sie_toggle));
  endtask
  task automatic t_clock();
    for (int f = 0; f < 4; f++) begin
      input_freq_select = 2'(f);
      repeat (2) @(negedge ref_clk);
      chk("ratio", 25'(6'h08 >> f), 25'(pll_ratio));
    end
    // first pass runs the 48 MHz bypass with the pll left off
    for (int p = 0; p < 2; p++) begin
      input_freq_select = p ? 2'h0 : 2'h3;
      osc_enable_bit = 1'b1;
      repeat (6) @(negedge ref_clk);
      pll_run_bit = 1'(p);
      for (int i = 0; i < 40 && pll_locked !== 1'b1; i++) @(negedge ref_clk);
      chk("lock", 25'h1, 25'(pll_locked));
      chk("osc pll", 25'({1'b1, 1'(p)}), 25'({osc_run, pll_on}));
      usb_clock_enable_bit = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk("usb clock", 25'h1, 25'(usb_clk_en));
      osc_enable_bit = 1'b0;
      pll_run_bit = 1'b0;
      usb_clock_enable_bit = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("stopped", 25'h0, 25'({pll_locked, usb_clk_en}));
      chk("osc pll off", 25'h0, 25'({osc_run, pll_on}));
    end
  endtask
  initial begin
    t_narrow();
    t_wide();
    t_count();
    t_toggle();
    t_clock();
    end_sim();
  end
endmodule // testbench
